/* File: verilog/lsc_cfg.svh */
`ifndef LSC_CFG_SVH
`define LSC_CFG_SVH

// register indices; the byte address is four times the index
`define LSC_IDX_A_ON 16'h4084
`define LSC_IDX_A_SLP 16'h4085
`define LSC_IDX_B_ON 16'h4087
`define LSC_IDX_B_SLP 16'h4088

// reset values
`define LSC_RST_A_ON 16'h0000
`define LSC_RST_A_SLP 16'h0100
`define LSC_RST_B_ON 16'h0000
`define LSC_RST_B_SLP 16'h0000

// implemented bits; all others read as zero
`define LSC_MASK_A_ON 16'hE11F
`define LSC_MASK_A_SLP 16'hE11F
`define LSC_MASK_B_ON 16'hF08F
`define LSC_MASK_B_SLP 16'hE00F

// field positions
`define LSC_SLOT_MSB 15
`define LSC_SLOT_LSB 13
`define LSC_FORCE_BIT 12
`define LSC_MODE_BIT 8
`define LSC_VSRC_BIT 7
`define LSC_VOLT_MSB 4

// bus answers
`define LSC_RESP_OKAY 2'h0
`define LSC_RESP_SLVERR 2'h2

`endif

/* File: verilog/lsc_pkg.sv */
package lsc_pkg;

  typedef enum logic [1:0] {RS_OFF, RS_ON, RS_SLEEP, RS_DOWN} lsc_rstate_t;

  // sequencer status, same clock domain
  typedef struct packed {
    logic on_seq;
    logic sleep_seq;
    logic off_req;
    logic tick;
    logic [2:0] slot;
  } lsc_seq_t;

  typedef struct packed {
    logic enable;
    logic lowpower;
    logic follow_dcdc1;
    logic [4:0] voltage;
  } lsc_rout_t;

  typedef struct packed {
    logic dis;
    logic [2:0] slot;
  } lsc_sleep_t;

  function automatic lsc_sleep_t lsc_sleep_decode(input logic [2:0] code);
    lsc_sleep_t r;
    r = '{dis: 1'b0, slot: 3'h5};
    unique case (code)
      3'h0: r = '{dis: 1'b0, slot: 3'h5};
      3'h1: r = '{dis: 1'b1, slot: 3'h5};
      3'h2: r = '{dis: 1'b1, slot: 3'h4};
      3'h3: r = '{dis: 1'b1, slot: 3'h3};
      3'h4: r = '{dis: 1'b1, slot: 3'h2};
      3'h5: r = '{dis: 1'b1, slot: 3'h1};
      3'h6: r = '{dis: 1'b0, slot: 3'h3};
      3'h7: r = '{dis: 1'b0, slot: 3'h1};
    endcase
    return r;
  endfunction : lsc_sleep_decode

endpackage : lsc_pkg

/* File: verilog/lsc_top.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "lsc_cfg.svh"

module lsc_top
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power sequencer
  input wire lsc_seq_t seq,
  // hardware enable pins 1 and 2, asynchronous
  input wire logic [1:0] hw_enable,
  // regulator controls
  output lsc_rout_t regulator_a,
  output lsc_rout_t regulator_b
);

  localparam logic [15:0] RST [4] = '{`LSC_RST_A_ON, `LSC_RST_A_SLP,
                                      `LSC_RST_B_ON, `LSC_RST_B_SLP};
  localparam logic [15:0] MASK [4] = '{`LSC_MASK_A_ON, `LSC_MASK_A_SLP,
                                       `LSC_MASK_B_ON, `LSC_MASK_B_SLP};

  // entries: 0 A on, 1 A sleep, 2 B on, 3 B sleep
  logic [15:0] regs [4];

  logic aw_full;
  logic [31:0] aw_addr;
  logic w_full;
  logic [15:0] w_data;
  logic [1:0] w_strb;
  logic wr_go;
  logic [2:0] wsel;
  logic [2:0] rsel;

  function automatic logic [2:0] dec_addr(input logic [31:0] a);
    logic [2:0] r;
    r = 3'h0;
    if (a[1:0] == 2'h0) begin
      if (a[31:2] == 30'(`LSC_IDX_A_ON)) r = 3'h4;
      if (a[31:2] == 30'(`LSC_IDX_A_SLP)) r = 3'h5;
      if (a[31:2] == 30'(`LSC_IDX_B_ON)) r = 3'h6;
      if (a[31:2] == 30'(`LSC_IDX_B_SLP)) r = 3'h7;
    end
    return r;
  endfunction : dec_addr

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] d,
                                        input logic [1:0] s,
                                        input logic [15:0] m);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r & m;
  endfunction : merge

  // write channel: address and data are caught in either order
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_go = aw_full && w_full && !s_axi_bvalid;
  assign wsel = dec_addr(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 32'h0000_0000;
    end else if (s_axi_awvalid && !aw_full) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 16'h0000;
      w_strb <= 2'h0;
    end else if (s_axi_wvalid && !w_full) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata[15:0];
      w_strb <= s_axi_wstrb[1:0];
    end else if (wr_go) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LSC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wsel[2] ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register file; upper byte lanes carry no bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 4; k++) begin
        regs[k] <= RST[k];
      end
    end else if (wr_go && wsel[2]) begin
      regs[wsel[1:0]] <= merge(regs[wsel[1:0]], w_data, w_strb, MASK[wsel[1:0]]);
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rsel = dec_addr(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `LSC_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rsel[2] ? {16'h0000, regs[rsel[1:0]]} : 32'h0000_0000;
      s_axi_rresp <= rsel[2] ? `LSC_RESP_OKAY : `LSC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // hardware enable pins: only the second stage is read
  logic [1:0] hw_s1;
  logic [1:0] hw_s2;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hw_s1 <= 2'h0;
      hw_s2 <= 2'h0;
    end else begin
      hw_s1 <= hw_enable;
      hw_s2 <= hw_s1;
    end
  end

  lsc_rstate_t st [2];
  lsc_rout_t rout [2];
  logic [2:0] on_code [2];
  logic [2:0] slp_code [2];
  logic hw_ctl [2];
  lsc_sleep_t sdec [2];
  logic sleep_hit [2];

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_reg
      logic [15:0] onr;
      logic [15:0] slr;
      logic hw_lvl;
      logic run;
      assign onr = regs[2*i];
      assign slr = regs[2*i+1];
      assign on_code[i] = onr[`LSC_SLOT_MSB:`LSC_SLOT_LSB];
      assign slp_code[i] = slr[`LSC_SLOT_MSB:`LSC_SLOT_LSB];
      // 110 and 111 hand the regulator to hardware enable 1 or 2
      assign hw_ctl[i] = on_code[i][2] && on_code[i][1];
      assign hw_lvl = hw_s2[on_code[i][0]];
      assign sdec[i] = lsc_sleep_decode(slp_code[i]);
      assign sleep_hit[i] = seq.sleep_seq && seq.tick && seq.slot == sdec[i].slot;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          st[i] <= RS_OFF;
        end else if (seq.off_req) begin
          st[i] <= RS_OFF;
        end else if (seq.on_seq && seq.tick) begin
          // on settings come back on every return to ON
          if (hw_ctl[i] || (on_code[i] != 3'h0 && seq.slot == on_code[i])) begin
            st[i] <= RS_ON;
          end
        end else if (sleep_hit[i] && st[i] == RS_ON) begin
          // a hardware-enabled regulator is never cut, only put to sleep
          st[i] <= (sdec[i].dis && !hw_ctl[i]) ? RS_DOWN : RS_SLEEP;
        end
      end

      assign run = st[i] == RS_ON || st[i] == RS_SLEEP;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rout[i] <= '0;
        end else begin
          rout[i].enable <= onr[`LSC_FORCE_BIT] || (hw_ctl[i] ? hw_lvl : run);
          rout[i].follow_dcdc1 <= onr[`LSC_VSRC_BIT];
          if (st[i] == RS_SLEEP) begin
            rout[i].lowpower <= slr[`LSC_MODE_BIT];
            rout[i].voltage <= slr[`LSC_VOLT_MSB:0];
          end else begin
            rout[i].lowpower <= onr[`LSC_MODE_BIT];
            rout[i].voltage <= onr[`LSC_VOLT_MSB:0];
          end
        end
      end
    end
  endgenerate

  assign regulator_a = rout[0];
  assign regulator_b = rout[1];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sleep_disable;
    sleep_hit[0] && st[0] == RS_ON && sdec[0].dis && !hw_ctl[0] && !seq.off_req
      && !seq.on_seq |=> st[0] == RS_DOWN ##1 !regulator_a.enable || regs[0][12];
  endproperty
  a_sleep_disable: assert property (p_sleep_disable)
    else $error("regulator a not disabled at its sleep slot");

  property p_sleep_keep;
    sleep_hit[1] && st[1] == RS_ON && !sdec[1].dis && !hw_ctl[1] && !seq.off_req
      && !seq.on_seq ##1 !seq.off_req && !(seq.on_seq && seq.tick)
      |-> st[1] == RS_SLEEP ##1 regulator_b.enable;
  endproperty
  a_sleep_keep: assert property (p_sleep_keep)
    else $error("regulator b not kept on in sleep transition");

  property p_hw_sleep;
    sleep_hit[0] && st[0] == RS_ON && sdec[0].dis && hw_ctl[0] && !seq.off_req
      && !seq.on_seq |=> st[0] == RS_SLEEP;
  endproperty
  a_hw_sleep: assert property (p_hw_sleep)
    else $error("hardware-enabled regulator disabled in sleep");

  property p_a_mode;
    st[0] == RS_SLEEP |=> regulator_a.lowpower == $past(regs[1][8]);
  endproperty
  a_a_mode: assert property (p_a_mode)
    else $error("regulator a sleep mode wrong");

  property p_a_volt;
    st[0] == RS_SLEEP |=> regulator_a.voltage == $past(regs[1][4:0]);
  endproperty
  a_a_volt: assert property (p_a_volt)
    else $error("regulator a sleep voltage wrong");

  property p_b_on;
    seq.on_seq && seq.tick && !seq.off_req && on_code[1] == seq.slot
      && on_code[1] != 3'h0 && !hw_ctl[1] |=> st[1] == RS_ON ##1 regulator_b.enable;
  endproperty
  a_b_on: assert property (p_b_on)
    else $error("regulator b not enabled in its on slot");

  property p_a_on;
    seq.on_seq && seq.tick && !seq.off_req && on_code[0] == seq.slot
      && on_code[0] != 3'h0 && !hw_ctl[0] |=> st[0] == RS_ON ##1 regulator_a.enable;
  endproperty
  a_a_on: assert property (p_a_on)
    else $error("regulator a not enabled in its on slot");

  property p_force;
    regs[2][12] |=> regulator_b.enable;
  endproperty
  a_force: assert property (p_force)
    else $error("regulator b force-on ignored");

  property p_vsrc;
    $changed(regs[2][7]) |=> regulator_b.follow_dcdc1 == $past(regs[2][7]);
  endproperty
  a_vsrc: assert property (p_vsrc)
    else $error("regulator b voltage source not followed");

  property p_b_onv;
    st[1] == RS_ON |=> regulator_b.voltage == {1'b0, $past(regs[2][3:0])};
  endproperty
  a_b_onv: assert property (p_b_onv)
    else $error("regulator b on voltage wrong");

  property p_b_slpv;
    st[1] == RS_SLEEP |=> regulator_b.voltage == {1'b0, $past(regs[3][3:0])};
  endproperty
  a_b_slpv: assert property (p_b_slpv)
    else $error("regulator b sleep voltage wrong");

  property p_a_hw;
    hw_ctl[0] && regs[0][12] == 1'b0 ##1 hw_ctl[0]
      |-> regulator_a.enable == $past(hw_s2[on_code[0][0]]);
  endproperty
  a_a_hw: assert property (p_a_hw)
    else $error("regulator a hardware enable not followed");

  property p_no_early_sleep;
    st[0] == RS_ON && !sleep_hit[0] && !seq.off_req |=> st[0] == RS_ON;
  endproperty
  a_no_early_sleep: assert property (p_no_early_sleep)
    else $error("regulator a left on state outside sleep slot");

  // a sleeping regulator must take its on settings back at its own on slot
  property p_wake;
    st[1] == RS_SLEEP && seq.on_seq && seq.tick && !seq.off_req && on_code[1] == seq.slot
      && on_code[1] != 3'h0 |=> st[1] == RS_ON;
  endproperty
  a_wake: assert property (p_wake)
    else $error("regulator b not back on after wake");

  c_sleep_down: cover property (st[0] == RS_ON ##1 st[0] == RS_DOWN);
  c_sleep_keep: cover property (st[1] == RS_ON ##1 st[1] == RS_SLEEP);
  c_wake: cover property (st[1] == RS_SLEEP ##1 st[1] == RS_ON);
  c_hw_sleep: cover property (hw_ctl[0] && st[0] == RS_ON ##1 st[0] == RS_SLEEP);
  c_write: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0);

endmodule : lsc_top

/* File: verification/ldo_sleep_on_slot_control_tb_top.sv */
`timescale 1ns/10ps
`include "lsc_cfg.svh"

module ldo_sleep_on_slot_control_tb_top import lsc_pkg::*; ();
  logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wrd, bv, arr, rv;
  logic [31:0] awa, wda, ara, rdt;
  logic [1:0] br, rr, hwe, r;
  logic [31:0] d;
  lsc_seq_t seq;
  lsc_rout_t ra, rb, o;
  logic [2:0] oc, ss;
  logic [4:0] ov, sv;
  logic md, sm, vs, hit;
  int error_cnt, comparisons;
  logic [15:0] ix [4] = '{`LSC_IDX_A_ON, `LSC_IDX_A_SLP, `LSC_IDX_B_ON, `LSC_IDX_B_SLP};
  logic [15:0] mk [4] = '{`LSC_MASK_A_ON, `LSC_MASK_A_SLP, `LSC_MASK_B_ON, `LSC_MASK_B_SLP};
  logic [15:0] rs [4] = '{`LSC_RST_A_ON, `LSC_RST_A_SLP, `LSC_RST_B_ON, `LSC_RST_B_SLP};

  lsc_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wda), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .seq(seq), .hw_enable(hwe), .regulator_a(ra), .regulator_b(rb));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      error_cnt++;
    end
  endtask : chk

  task automatic wr(input logic [15:0] i, input logic [15:0] w, output logic [1:0] p);
    @(posedge aclk);
    awa <= {14'h0000, i, 2'h0};
    wda <= {16'h0000, w};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    p = br;
    bry <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] i, output logic [31:0] q, output logic [1:0] p);
    @(posedge aclk);
    ara <= {14'h0000, i, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    q = rdt;
    p = rr;
    rry <= 1'b0;
  endtask : rd

  // a tick pulse is sampled one edge after it is driven; outputs follow one edge later
  task automatic tk(input logic on, input logic sl, input logic off, input logic [2:0] t);
    @(posedge aclk);
    seq <= '{on_seq: on, sleep_seq: sl, off_req: off, tick: 1'b1, slot: t};
    @(posedge aclk);
    seq <= '0;
    @(posedge aclk);
    #1;
  endtask : tk

  // pin passes a two-stage synchroniser and an output register
  task automatic pin(input logic [1:0] v);
    @(posedge aclk);
    hwe <= v;
    repeat (4) @(posedge aclk);
    #1;
  endtask : pin

  function automatic logic [2:0] sslot(input logic [2:0] c);
    return (c < 3'h2) ? 3'h5 : (c == 3'h6) ? 3'h3 : (c == 3'h7) ? 3'h1 : 3'h6 - c;
  endfunction : sslot

  initial begin
    #(25 * 20000);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {aresetn, awv, wv, bry, arv, rry, awa, wda, ara, hwe} = '0;
    seq = '0;
    void'($urandom(32'hbaab));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rd(ix[k], d, r);
      chk("reset value", {16'h0000, rs[k]}, d);
      wr(ix[k], 16'($urandom), r);
      chk("write resp", `LSC_RESP_OKAY, r);
      sv = 5'($urandom);
      wr(ix[k], {sv, sv, sv, 1'b1}, r);
      rd(ix[k], d, r);
      chk("readback", {16'h0000, {sv, sv, sv, 1'b1} & mk[k]}, d);
    end
    wr(16'h4086, 16'hffff, r);
    chk("unmapped write", `LSC_RESP_SLVERR, r);
    rd(16'h4086, d, r);
    chk("unmapped read", {30'h0000_0000, `LSC_RESP_SLVERR}, {d[29:0], r});
    for (int g = 0; g < 2; g++) begin
      for (int s = 0; s < 8; s++) begin
        oc = 3'(s % 5 + 1);
        ov = 5'($urandom) & (g ? 5'h0f : 5'h1f);
        sv = 5'($urandom) & (g ? 5'h0f : 5'h1f);
        {md, sm, vs} = 3'($urandom);
        tk(1'b0, 1'b0, 1'b1, 3'h0);
        if (g == 0) begin
          wr(ix[0], {oc, 4'h0, md, 3'h0, ov}, r);
          wr(ix[1], {3'(s), 4'h0, sm, 3'h0, sv}, r);
        end else begin
          wr(ix[2], {oc, 5'h00, vs, 2'h0, ov}, r);
          wr(ix[3], {3'(s), 9'h000, sv[3:0]}, r);
        end
        for (int t = 1; t < 6; t++) begin
          tk(1'b1, 1'b0, 1'b0, 3'(t));
          o = g ? rb : ra;
          chk("on enable", oc <= t, o.enable);
        end
        if (g == 1) chk("source", vs, rb.follow_dcdc1);
        for (int t = 5; t > 0; t--) begin
          tk(1'b0, 1'b1, 1'b0, 3'(t));
          o = g ? rb : ra;
          hit = t <= sslot(3'(s));
          chk("sleep enable", !(hit && s > 0 && s < 6), o.enable);
          if (!o.enable) continue;
          chk("sleep voltage", hit ? sv : ov, o.voltage);
          if (g == 0) chk("sleep mode", hit ? sm : md, o.lowpower);
        end
        tk(1'b1, 1'b0, 1'b0, oc);
        o = g ? rb : ra;
        chk("wake voltage", {1'b1, ov}, {o.enable, o.voltage});
      end
    end
    tk(1'b0, 1'b0, 1'b1, 3'h0);
    wr(ix[3], 16'h2009, r);
    wr(ix[2], 16'hc003, r);
    wr(ix[1], 16'h2005, r);
    wr(ix[0], 16'hc01f, r);
    pin(2'h1);
    tk(1'b1, 1'b0, 1'b0, 3'h1);
    chk("hw enable 1", 1'b1, rb.enable);
    chk("hw enable a", 1'b1, ra.enable);
    tk(1'b0, 1'b1, 1'b0, 3'h5);
    chk("hw sleep", 6'h29, {rb.enable, rb.voltage});
    chk("hw sleep a", 6'h25, {ra.enable, ra.voltage});
    pin(2'h0);
    chk("hw pin low", 1'b0, rb.enable);
    chk("hw pin low a", 1'b0, ra.enable);
    wr(ix[2], 16'he003, r);
    pin(2'h2);
    chk("hw enable 2", 1'b1, rb.enable);
    pin(2'h0);
    wr(ix[2], 16'h1000, r);
    tk(1'b0, 1'b0, 1'b1, 3'h0);
    chk("force in off", 1'b1, rb.enable);
    wr(ix[2], 16'h0000, r);
    tk(1'b1, 1'b0, 1'b0, 3'h1);
    chk("slot zero", 1'b0, rb.enable);
    give_verdict();
  end
endmodule : ldo_sleep_on_slot_control_tb_top
